// File: logic/gpp_params.svh
// Offsets, field positions and reset values of the port block.
// Assumes inclusion by bare name from the design files.
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

`define GPP_OFF_P2       12'h000
`define GPP_OFF_PM2      12'h004
`define GPP_OFF_ANALOG_MODE_SELECT_BITS     12'h008
`define GPP_OFF_PU2      12'h00C
`define GPP_OFF_P3       12'h010
`define GPP_OFF_PM3      12'h014
`define GPP_OFF_IRQ_STAT 12'h018
`define GPP_OFF_IRQ_CLR  12'h01C
`define GPP_OFF_IRQ_EN   12'h020
`define GPP_OFF_CFG      12'h024
`define GPP_OFF_PIN2     12'h028
`define GPP_OFF_PIN3     12'h02C

`define GPP_RST_LATCH    8'h00
`define GPP_RST_MODE     8'hFF
`define GPP_RST_AMODE    4'h0
`define GPP_RST_PU       8'h00
`define GPP_PD_MASK      8'h0C

`define GPP_BIT_IRQA     1
`define GPP_BIT_IRQB     2
`define GPP_BIT_RSTPIN   4
`define GPP_CFG_RDY      2
`define GPP_CFG_PORT     1

`endif

// File: logic/gpp_pkg.sv
// Types shared by the port block modules.
// Assumes the params header is on the include path.
package gpp_pkg;
   typedef logic [7:0] gpp_byte_t;
   typedef enum logic [1:0] {
      GPP_RST_HOLD = 2'b00,
      GPP_CFG_READ = 2'b01,
      GPP_RUN      = 2'b10
   } gpp_rst_e;
endpackage : gpp_pkg

// File: logic/gpp_port.sv
// Port 2 / port 3 logic with APB registers, reset pin sharing, irqs.
// Assumes an APB master on clk_in and pads resolving the enables.
//
// What this block does
// - Shared oscillator pins pulled down during reset
// - Port-assigned reset pin ignored as reset after config read
// - Config read after release; low pin holds reset
// - Output level change on irq pin sets flag
// - Analog select turns off digital output drive and pull-up
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_port (
   // Clock and reset
   input  wire logic            clk_in,
   input  wire logic            rst_n_in,
   // APB slave
   input  wire logic            psel_in,
   input  wire logic            penable_in,
   input  wire logic            pwrite_in,
   input  wire logic [11:0]     paddr_in,
   input  wire logic [31:0]     pwdata_in,
   output logic      [31:0]     prdata_out,
   output logic                 pready_out,
   output logic                 pslverr_out,
   // Option byte source
   input  wire logic            cfg_valid_in,
   input  wire logic            cfg_port_mode_in,
   // Port pins
   input  wire gpp_pkg::gpp_byte_t p2_pin_in,
   output gpp_pkg::gpp_byte_t   p2_pin_out,
   output gpp_pkg::gpp_byte_t   p2_oe_n_out,
   output gpp_pkg::gpp_byte_t   p2_pulldown_out,
   output gpp_pkg::gpp_byte_t   p2_pullup_out,
   output logic      [3:0]      analog_en_out,
   input  wire gpp_pkg::gpp_byte_t p3_pin_in,
   output gpp_pkg::gpp_byte_t   p3_pin_out,
   output gpp_pkg::gpp_byte_t   p3_oe_n_out,
   // System
   output logic                 core_rst_n_out,
   output logic                 irq_out
);
   import gpp_pkg::*;

   // -----------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------
   gpp_byte_t p2_s, p3_s;
   gpp_sync2 #(.W(8)) u_s2 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .d_in(p2_pin_in), .q_out(p2_s));
   gpp_sync2 #(.W(8)) u_s3 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .d_in(p3_pin_in), .q_out(p3_s));

   // -----------------------------------------------------
   // Reset sequencing
   // -----------------------------------------------------
   gpp_rst_e st_r;
   logic     port_mode_r;
   wire      rst_pin_low = !p3_s[`GPP_BIT_RSTPIN];
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_r        <= GPP_RST_HOLD;
         port_mode_r <= 1'b0;
      end else begin
         case (st_r)
            GPP_RST_HOLD: st_r <= GPP_CFG_READ;
            GPP_CFG_READ: begin
               if (cfg_valid_in && !rst_pin_low) begin
                  port_mode_r <= cfg_port_mode_in;
                  st_r        <= GPP_RUN;
               end
            end
            GPP_RUN: begin
               if (!port_mode_r && rst_pin_low)
                  st_r <= GPP_RST_HOLD;
            end
            default: st_r <= GPP_RST_HOLD;
         endcase
      end
   end
   wire in_reset = (st_r != GPP_RUN);
   assign core_rst_n_out = !in_reset;

   // -----------------------------------------------------
   // Port registers
   // -----------------------------------------------------
   gpp_byte_t p2_r, pm2_r, pu2_r, p3_r, pm3_r;
   logic [3:0] analog_mode_select_bits_r;
   logic [2:0] ist_r, ien_r;
   wire acc = psel_in && penable_in;
   wire wr  = acc && pwrite_in && !in_reset;
   // Whole-byte write; bit ops are read-modify-write of the byte
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || in_reset) begin
         p2_r   <= `GPP_RST_LATCH;
         pm2_r  <= `GPP_RST_MODE;
         pu2_r  <= `GPP_RST_PU;
         analog_mode_select_bits_r <= `GPP_RST_AMODE;
         p3_r   <= `GPP_RST_LATCH;
         pm3_r  <= `GPP_RST_MODE;
         ien_r  <= 3'h0;
      end else if (wr) begin
         case (paddr_in)
            `GPP_OFF_P2:     p2_r   <= pwdata_in[7:0];
            `GPP_OFF_PM2:    pm2_r  <= pwdata_in[7:0];
            `GPP_OFF_ANALOG_MODE_SELECT_BITS:   analog_mode_select_bits_r <= pwdata_in[3:0];
            `GPP_OFF_PU2:    pu2_r  <= pwdata_in[7:0];
            `GPP_OFF_P3:     p3_r   <= pwdata_in[7:0];
            `GPP_OFF_PM3:    pm3_r  <= pwdata_in[7:0];
            `GPP_OFF_IRQ_EN: ien_r  <= pwdata_in[2:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------
   // Pin drive
   // -----------------------------------------------------
   gpp_byte_t amask;
   assign amask = {4'h0, analog_mode_select_bits_r};
   always_comb begin
      p2_oe_n_out = in_reset ? 8'hFF : (pm2_r | amask);
      p3_oe_n_out = in_reset ? 8'hFF : pm3_r;
      p2_pulldown_out = in_reset ? `GPP_PD_MASK : 8'h00;
      p2_pullup_out   = in_reset ? 8'h00 : (pu2_r & ~amask);
      analog_en_out   = in_reset ? 4'h0 : analog_mode_select_bits_r;
   end
   assign p2_pin_out = p2_r;
   assign p3_pin_out = p3_r;

   // -----------------------------------------------------
   // Interrupt flags from driven-level changes and the reset pin going low
   // -----------------------------------------------------
   logic a_prev_r, b_prev_r;
   wire a_drv = !pm2_r[`GPP_BIT_IRQA];
   wire b_drv = !pm3_r[`GPP_BIT_IRQB];
   wire ev_a = a_drv && (p2_r[`GPP_BIT_IRQA] != a_prev_r);
   wire ev_b = b_drv && (p3_r[`GPP_BIT_IRQB] != b_prev_r);
   wire ev_c = (st_r == GPP_RUN) && !port_mode_r && rst_pin_low;
   wire [2:0] ev = {ev_c, ev_b, ev_a};
   wire clr = wr && (paddr_in == `GPP_OFF_IRQ_CLR);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         a_prev_r <= 1'b0;
         b_prev_r <= 1'b0;
         ist_r    <= 3'h0;
      end else begin
         a_prev_r <= p2_r[`GPP_BIT_IRQA];
         b_prev_r <= p3_r[`GPP_BIT_IRQB];
         // Set wins over clear
         ist_r <= (ist_r & ~(clr ? pwdata_in[2:0] : 3'h0)) | ev;
      end
   end
   assign irq_out = |(ist_r & ien_r);

   // -----------------------------------------------------
   // APB read
   // -----------------------------------------------------
   function automatic logic known(input logic [11:0] a);
      known = (a <= `GPP_OFF_PIN3) && (a[1:0] == 2'b00);
   endfunction
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         case (paddr_in)
            `GPP_OFF_P2:       prdata_out <= {24'h0, p2_r};
            `GPP_OFF_PM2:      prdata_out <= {24'h0, pm2_r};
            `GPP_OFF_ANALOG_MODE_SELECT_BITS:     prdata_out <= {28'h0, analog_mode_select_bits_r};
            `GPP_OFF_PU2:      prdata_out <= {24'h0, pu2_r};
            `GPP_OFF_P3:       prdata_out <= {24'h0, p3_r};
            `GPP_OFF_PM3:      prdata_out <= {24'h0, pm3_r};
            `GPP_OFF_IRQ_STAT: prdata_out <= {29'h0, ist_r};
            `GPP_OFF_IRQ_EN:   prdata_out <= {29'h0, ien_r};
            `GPP_OFF_CFG:      prdata_out <= {30'h0, !in_reset,
                                              port_mode_r};
            // Input pins read pins, outputs read latch
            `GPP_OFF_PIN2: prdata_out <= {24'h0,
               ((pm2_r | amask) & p2_s) | (~(pm2_r | amask) & p2_r)};
            `GPP_OFF_PIN3: prdata_out <= {24'h0,
               (pm3_r & p3_s) | (~pm3_r & p3_r)};
            default:           prdata_out <= 32'h0;
         endcase
      end
   end
   assign pready_out  = 1'b1;
   assign pslverr_out = acc && !known(paddr_in);

   // -----------------------------------------------------
   // Checks
   // -----------------------------------------------------
   property p_pd_reset;
      @(posedge clk_in) disable iff (!rst_n_in)
      in_reset |-> (p2_pulldown_out == `GPP_PD_MASK);
   endproperty
   a_pd_reset: assert property (p_pd_reset)
      else $error("pull-downs not active in reset");
   property p_pd_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      !in_reset |-> (p2_pulldown_out == 8'h00);
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("pull-downs left on after reset");
   property p_port_mode;
      @(posedge clk_in) disable iff (!rst_n_in)
      (st_r == GPP_RUN && port_mode_r) |=> (st_r == GPP_RUN);
   endproperty
   a_port_mode: assert property (p_port_mode)
      else $error("port-mode pin caused reset");
   property p_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      (st_r == GPP_CFG_READ && rst_pin_low) |=> (st_r != GPP_RUN);
   endproperty
   a_hold: assert property (p_hold)
      else $error("left reset with reset pin low");
   property p_flag;
      @(posedge clk_in) disable iff (!rst_n_in)
      (a_drv && $changed(p2_r[`GPP_BIT_IRQA])) |=> ist_r[0];
   endproperty
   a_flag: assert property (p_flag)
      else $error("output change did not set flag");
   property p_analog;
      @(posedge clk_in) disable iff (!rst_n_in)
      (!in_reset && analog_mode_select_bits_r[0]) |-> p2_oe_n_out[0] && !p2_pullup_out[0];
   endproperty
   a_analog: assert property (p_analog)
      else $error("digital drive on analog pin");
   property p_byte;
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr && paddr_in == `GPP_OFF_P2) |=> (p2_r == $past(pwdata_in[7:0]));
   endproperty
   a_byte: assert property (p_byte)
      else $error("port write not whole byte");
   property p_irq;
      @(posedge clk_in) disable iff (!rst_n_in)
      (ist_r[1] && ien_r[1]) |-> irq_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled flag without irq");
endmodule : gpp_port

// File: logic/gpp_sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes asynchronous inputs and one clock.
`timescale 1ns/1ps
module gpp_sync2 #(
   parameter int W = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_r;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s1_r  <= '0;
         q_out <= '0;
      end else begin
         s1_r  <= d_in;
         q_out <= s1_r;
      end
   end
endmodule : gpp_sync2

// File: tb/gpp_pin_model.sv
// Board side of the port pins: device drive, board drive, pulls.
// Assumes active-low enables from the port block and one clock.
`timescale 1ns/1ps
module gpp_pin_model (
   // Clock
   input  wire logic       clk_in,
   // Device side of the pads
   input  wire logic [7:0] p2_out_in,
   input  wire logic [7:0] p2_oe_n_in,
   input  wire logic [7:0] p2_pd_in,
   input  wire logic [7:0] p2_pu_in,
   input  wire logic [7:0] p3_out_in,
   input  wire logic [7:0] p3_oe_n_in,
   // Board drivers from the bench
   input  wire logic [7:0] drv2_in,
   input  wire logic [7:0] en2_in,
   input  wire logic [7:0] drv3_in,
   input  wire logic [7:0] en3_in,
   // Resolved pin levels
   output logic      [7:0] p2_pin_out,
   output logic      [7:0] p3_pin_out
);
   // -------------------------------------------
   // Undriven pins without a pull wander
   // -------------------------------------------
   logic flip_r = 1'b0;
   always @(posedge clk_in) begin
      flip_r <= ~flip_r;
   end
   assign p2_pin_out = (~p2_oe_n_in & p2_out_in) | (p2_oe_n_in &
      ((en2_in & drv2_in) | (~en2_in & ~p2_pd_in & (p2_pu_in | {8{flip_r}}))));
   // Board pull-up on the reset pin
   assign p3_pin_out = (~p3_oe_n_in & p3_out_in) | (p3_oe_n_in &
      ((en3_in & drv3_in) | (~en3_in & (8'h10 | {8{flip_r}}))));
endmodule : gpp_pin_model

// File: tb/tb_top.sv
// Self-checking bench for the port block over APB.
// Assumes the pin model and the design files are compiled first.
`timescale 1ns/1ps
module tb_top;
   import gpp_pkg::*;
   logic        clk_in = 1'b0, rst_n_in = 1'b0;
   logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, v;
   logic        pready_out, pslverr_out, core_rst_n_out, irq_out;
   logic        cfg_valid_in = 1'b1, cfg_port_mode_in = 1'b0;
   gpp_byte_t   p2_pin_in, p2_pin_out, p2_oe_n_out, p2_pd, p2_pu;
   gpp_byte_t   p3_pin_in, p3_pin_out, p3_oe_n_out;
   gpp_byte_t   drv2 = 8'h00, en2 = 8'h00, drv3 = 8'h00, en3 = 8'h10;
   logic [3:0]  analog_en_out;
   logic [32:0] exp_q[$];
   int          n_fail = 0, comparisons = 0;

   always #5 clk_in = ~clk_in;

   gpp_port gpp_port_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .cfg_valid_in(cfg_valid_in), .cfg_port_mode_in(cfg_port_mode_in),
      .p2_pin_in(p2_pin_in), .p2_pin_out(p2_pin_out),
      .p2_oe_n_out(p2_oe_n_out), .p2_pulldown_out(p2_pd),
      .p2_pullup_out(p2_pu), .analog_en_out(analog_en_out),
      .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out),
      .p3_oe_n_out(p3_oe_n_out), .core_rst_n_out(core_rst_n_out),
      .irq_out(irq_out));
   gpp_pin_model gpp_pin_model_i (.clk_in(clk_in), .p2_out_in(p2_pin_out),
      .p2_oe_n_in(p2_oe_n_out), .p2_pd_in(p2_pd), .p2_pu_in(p2_pu),
      .p3_out_in(p3_pin_out), .p3_oe_n_in(p3_oe_n_out), .drv2_in(drv2),
      .en2_in(en2), .drv3_in(drv3), .en3_in(en3), .p2_pin_out(p2_pin_in),
      .p3_pin_out(p3_pin_in));

   // -------------------------------------------
   // Tasks
   // -------------------------------------------
   task automatic test_done;
      $display("counts: %0d compared, %0d failed", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [32:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   // Write: d is data; read: d is {pslverr, prdata} expected
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [32:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d[31:0];
      if (!w) exp_q.push_back(d);
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (n >= 20) begin
         n_fail++;
         test_done();
      end
   endtask : apb
   task automatic boot(input logic pm, input logic hold);
      int n;
      n = 0;
      rst_n_in <= 1'b0;
      cfg_port_mode_in <= pm;
      cyc(3);
      @(negedge clk_in);
      chk("pulldown", 8'h0C, p2_pd);
      chk("oe_n", 8'hFF, p2_oe_n_out);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      if (hold) begin
         cyc(20);
         chk("core_rst", 1'b0, core_rst_n_out);
         en3 <= 8'h00;
      end
      while (core_rst_n_out !== 1'b1 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 40) begin
         n_fail++;
         test_done();
      end
      chk("pulldown", 8'h00, p2_pd);
   endtask : boot

   // -------------------------------------------
   // Read-result monitor and main sequence
   // -------------------------------------------
   always @(posedge clk_in) begin
      if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
         chk("prdata", exp_q.pop_front(), {pslverr_out, prdata_out});
      end
   end
   initial begin
      void'($urandom(32'h579B));
      boot(1'b0, 1'b1);
      apb(1'b0, 12'h004, 33'h0_0000_00FF);
      apb(1'b0, 12'h024, 33'h0_0000_0002);
      $display("test boot ended");
      v = $urandom;
      apb(1'b1, 12'h000, {25'h0, v[7:0]});
      apb(1'b1, 12'h004, 33'h0);
      cyc(3);
      apb(1'b0, 12'h028, {25'h0, v[7:0]});
      chk("p2_latch", v[7:0], p2_pin_out);
      $display("test byte ended");
      apb(1'b1, 12'h020, 33'h3);
      apb(1'b1, 12'h01C, 33'h7);
      apb(1'b1, 12'h000, {25'h0, v[7:0] ^ 8'h02});
      cyc(3);
      @(negedge clk_in);
      chk("irq", 1'b1, irq_out);
      apb(1'b0, 12'h018, 33'h1);
      apb(1'b1, 12'h01C, 33'h1);
      @(negedge clk_in);
      chk("irq", 1'b0, irq_out);
      apb(1'b1, 12'h020, 33'h0);
      apb(1'b1, 12'h014, 33'hFB);
      apb(1'b1, 12'h010, 33'h4);
      cyc(3);
      @(negedge clk_in);
      chk("irq", 1'b0, irq_out);
      chk("p3_oe_n", 8'hFB, p3_oe_n_out);
      chk("p3_latch", 8'h04, p3_pin_out);
      apb(1'b0, 12'h018, 33'h2);
      $display("test flags ended");
      apb(1'b1, 12'h00C, 33'hF0);
      apb(1'b1, 12'h008, 33'hF);
      @(negedge clk_in);
      chk("analog", 4'hF, analog_en_out);
      chk("pullup", 8'hF0, p2_pu);
      chk("oe_n", 8'h0F, p2_oe_n_out);
      apb(1'b0, 12'h030, 33'h1_0000_0000);
      $display("test analog ended");
      boot(1'b1, 1'b0);
      en3 <= 8'h10;
      cyc(6);
      chk("core_rst", 1'b1, core_rst_n_out);
      en3 <= 8'h00;
      boot(1'b0, 1'b0);
      en3 <= 8'h10;
      cyc(6);
      chk("core_rst", 1'b0, core_rst_n_out);
      apb(1'b0, 12'h018, 33'h4);
      $display("test reset pin ended");
      test_done();
   end
endmodule : tb_top
